// >>> logic/period_timer_pkg.sv
// Package: register map, field layout and reset values of the period timer
package period_timer_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] COUNT_OFFSET = 12'h000;
  localparam logic [11:0] PERIOD_OFFSET = 12'h004;
  localparam logic [11:0] CONTROL_OFFSET = 12'h008;
  localparam logic [11:0] IRQ_OFFSET = 12'h00c;
  localparam logic [11:0] SYS_OFFSET = 12'h010;

  // ==========================================================================
  // Field positions
  localparam int CKPS_LSB = 0;
  localparam int TIMER_ON_BIT = 2;
  localparam int OUTPS_LSB = 3;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int SYS_SLEEP_BIT = 0;
  localparam int SYS_SPI_SEL_BIT = 1;

  // ==========================================================================
  // Reset values, and the divider value that marks an instruction tick
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] FOSC_DIV = 2'h3;

  // ==========================================================================
  // Control register layout
  typedef struct packed {
    logic unused;
    logic [3:0] output_postscale_select;
    logic timer_on;
    logic [1:0] clock_prescale_select;
  } timer_control_s;

  // Timer outputs towards the consumers
  typedef struct packed {
    logic match_pulse;
    logic spi_shift_clock;
    logic irq;
  } timer_out_s;

endpackage

// >>> logic/eight_bit_period_timer.sv
// Eight-bit period timer with prescaler, period comparator and postscaler, APB slave
`timescale 1ns/1ns
module eight_bit_period_timer (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer outputs
  output period_timer_pkg::timer_out_s tmr_out
);
  import period_timer_pkg::*;

  // ==========================================================================
  // Bus decode
  wire logic wr_en = psel & penable & pwrite & pstrb[0];
  wire logic hit_count = (paddr == COUNT_OFFSET);
  wire logic hit_period = (paddr == PERIOD_OFFSET);
  wire logic hit_control = (paddr == CONTROL_OFFSET);
  wire logic hit_irq = (paddr == IRQ_OFFSET);
  wire logic hit_sys = (paddr == SYS_OFFSET);
  wire logic hit_any = hit_count | hit_period | hit_control | hit_irq | hit_sys;
  wire logic wr_count = wr_en & hit_count;
  wire logic wr_period = wr_en & hit_period;
  wire logic wr_control = wr_en & hit_control;
  wire logic wr_irq = wr_en & hit_irq;
  wire logic wr_sys = wr_en & hit_sys;

  assign pready = 1'b1;
  // Unmapped addresses answer with an error so a stray access is visible
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================================
  // Registers
  logic [7:0] count_value_ff;
  logic [7:0] period_value_ff;
  timer_control_s timer_control_ff;
  logic match_irq_flag_ff;
  logic match_irq_enable_ff;
  logic sleep_ff;
  logic spi_sel_ff;
  logic [1:0] fosc_div_ff;
  logic [5:0] presc_ff;
  logic [3:0] postsc_ff;
  logic match_ff;
  logic [31:0] prdata_ff;

  // ==========================================================================
  // Tick generation
  wire logic running = timer_control_ff.timer_on & ~sleep_ff;
  wire logic instr_tick = (fosc_div_ff == FOSC_DIV);
  logic [5:0] presc_last;
  always_comb begin
    unique case (timer_control_ff.clock_prescale_select)
      2'h0: presc_last = 6'h00;
      2'h1: presc_last = 6'h03;
      2'h2: presc_last = 6'h0f;
      2'h3: presc_last = 6'h3f;
    endcase
  end
  wire logic scaler_clr = wr_count | wr_control;
  wire logic timer_tick = running & instr_tick & (presc_ff == presc_last);
  wire logic match_now = timer_tick & (count_value_ff == period_value_ff);
  wire logic post_done = match_now &
    (postsc_ff == timer_control_ff.output_postscale_select);

  // ==========================================================================
  // Next values
  wire logic [1:0] nxt_fosc_div = running ? fosc_div_ff + 2'h1 : fosc_div_ff;
  wire logic [5:0] nxt_presc = scaler_clr ? 6'h00 :
    (running & instr_tick) ? ((presc_ff == presc_last) ? 6'h00 : presc_ff + 6'h01) :
    presc_ff;
  wire logic [3:0] nxt_postsc = scaler_clr ? 4'h0 :
    post_done ? 4'h0 : match_now ? postsc_ff + 4'h1 : postsc_ff;
  wire logic [7:0] nxt_count = wr_count ? pwdata[7:0] :
    match_now ? 8'h00 : timer_tick ? count_value_ff + 8'h01 : count_value_ff;
  wire logic [7:0] nxt_period = wr_period ? pwdata[7:0] : period_value_ff;
  wire timer_control_s nxt_control = wr_control ?
    timer_control_s'({1'b0, pwdata[6:0]}) : timer_control_ff;
  // Hardware set wins over a software clear in the same cycle
  wire logic nxt_flag = post_done |
    (wr_irq ? pwdata[IRQ_FLAG_BIT] : match_irq_flag_ff);
  wire logic nxt_enable = wr_irq ? pwdata[IRQ_ENABLE_BIT] : match_irq_enable_ff;
  wire logic nxt_sleep = wr_sys ? pwdata[SYS_SLEEP_BIT] : sleep_ff;
  wire logic nxt_spi_sel = wr_sys ? pwdata[SYS_SPI_SEL_BIT] : spi_sel_ff;

  logic [31:0] nxt_prdata;
  always_comb begin
    nxt_prdata = 32'h0;
    if (hit_count) begin
      nxt_prdata[7:0] = count_value_ff;
    end else if (hit_period) begin
      nxt_prdata[7:0] = period_value_ff;
    end else if (hit_control) begin
      nxt_prdata[7:0] = timer_control_ff;
    end else if (hit_irq) begin
      nxt_prdata[IRQ_FLAG_BIT] = match_irq_flag_ff;
      nxt_prdata[IRQ_ENABLE_BIT] = match_irq_enable_ff;
    end else if (hit_sys) begin
      nxt_prdata[SYS_SLEEP_BIT] = sleep_ff;
      nxt_prdata[SYS_SPI_SEL_BIT] = spi_sel_ff;
    end
  end
  // Read data captured in the setup cycle so it is a flop in the access phase
  wire logic [31:0] nxt_prdata_hold = (psel & ~penable & ~pwrite) ? nxt_prdata : prdata_ff;

  // ==========================================================================
  // State
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_ff <= COUNT_RESET;
      period_value_ff <= PERIOD_RESET;
      timer_control_ff <= CONTROL_RESET;
      presc_ff <= 6'h00;
      postsc_ff <= 4'h0;
      fosc_div_ff <= 2'h0;
      match_irq_flag_ff <= 1'b0;
      match_irq_enable_ff <= 1'b0;
      sleep_ff <= 1'b0;
      spi_sel_ff <= 1'b0;
      match_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      count_value_ff <= nxt_count;
      period_value_ff <= nxt_period;
      timer_control_ff <= nxt_control;
      presc_ff <= nxt_presc;
      postsc_ff <= nxt_postsc;
      fosc_div_ff <= nxt_fosc_div;
      match_irq_flag_ff <= nxt_flag;
      match_irq_enable_ff <= nxt_enable;
      sleep_ff <= nxt_sleep;
      spi_sel_ff <= nxt_spi_sel;
      match_ff <= match_now;
      prdata_ff <= nxt_prdata_hold;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = prdata_ff;
  assign tmr_out.match_pulse = match_ff;
  assign tmr_out.spi_shift_clock = spi_sel_ff & match_ff;
  assign tmr_out.irq = match_irq_flag_ff & match_irq_enable_ff;

endmodule

// >>> testbench/period_timer_chk.sv
// Checker: port assertions for the period timer
`timescale 1ns/1ns
module period_timer_chk
  import period_timer_pkg::*;
(
  // Ports watched
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire period_timer_pkg::timer_out_s tmr_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pwrite && pstrb[0];
  wire mapped = paddr inside {COUNT_OFFSET, PERIOD_OFFSET, CONTROL_OFFSET, IRQ_OFFSET, SYS_OFFSET};
  // Window of four quiet cycles: a restart needs at least one more bus transfer
  wire stop_wr = wr && paddr == CONTROL_OFFSET && !pwdata[TIMER_ON_BIT];
  wire nap_wr = wr && paddr == SYS_OFFSET && pwdata[SYS_SLEEP_BIT];
  AST_ERR: assert property (acc |-> pslverr == !mapped) else $error("bad slave error");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("stray slave error");
  AST_READY: assert property (acc |-> pready) else $error("access without ready");
  AST_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper");
  AST_PULSE: assert property (tmr_out.match_pulse |=> !tmr_out.match_pulse [*3])
    else $error("match pulses too close");
  AST_SPI: assert property (tmr_out.spi_shift_clock |-> tmr_out.match_pulse)
    else $error("shift clock without match");
  AST_IRQ_FALL: assert property ($fell(tmr_out.irq) |-> $past(wr)) else $error("irq fell");
  AST_IRQ_RISE: assert property ($rose(tmr_out.irq) |->
    $past(wr) || tmr_out.match_pulse || $past(tmr_out.match_pulse)) else $error("irq rose");
  AST_STOP: assert property (stop_wr |=> ##1 !tmr_out.match_pulse [*4])
    else $error("match while stopped");
  AST_SLEEP: assert property (nap_wr |=> ##1 !tmr_out.match_pulse [*4])
    else $error("match while asleep");
endmodule
bind eight_bit_period_timer period_timer_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .tmr_out);

// >>> testbench/eight_bit_period_timer_bench.sv
// Testbench: self-checking bench for the eight-bit period timer
`timescale 1ns/1ns
module eight_bit_period_timer_bench;
  import period_timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  timer_out_s tmr_out;
  int errors, checks_done, seed, cyc, n;
  int outps[3] = '{0, 3, 15};
  eight_bit_period_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .tmr_out);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Ceiling well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task automatic gap(output int c);
    c = 0;
    do @(posedge pclk); while (tmr_out.match_pulse !== 1'b1);
    do begin
      @(posedge pclk);
      c++;
    end while (tmr_out.match_pulse !== 1'b1);
  endtask
  task automatic frozen();
    apb(0, COUNT_OFFSET, 0);
    n = rd;
    repeat (100) @(posedge pclk);
    rchk(COUNT_OFFSET, n);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    seed = 33;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rchk(COUNT_OFFSET, 0);
    rchk(PERIOD_OFFSET, 8'hff);
    rchk(CONTROL_OFFSET, 0);
    repeat (4) begin
      n = $random(seed) & 8'hff;
      apb(1, COUNT_OFFSET, n);
      apb(1, PERIOD_OFFSET, n ^ 8'hff);
      rchk(COUNT_OFFSET, n);
      rchk(PERIOD_OFFSET, n ^ 8'hff);
    end
    apb(1, 12'h014, 8'h5a);
    rchk(12'h014, 0);
    chk(err, 1);
    apb(1, COUNT_OFFSET, 8'h37);
    apb(1, CONTROL_OFFSET, 8'h78);
    rchk(COUNT_OFFSET, 8'h37);
    $display("register tests done");
    apb(1, PERIOD_OFFSET, 2);
    for (int ps = 0; ps < 4; ps++) begin
      apb(1, CONTROL_OFFSET, 4 | ps);
      gap(n);
      chk(n, 12 << (2 * ps));
    end
    $display("prescaler tests done");
    apb(1, PERIOD_OFFSET, 1);
    foreach (outps[i]) begin
      apb(1, CONTROL_OFFSET, 0);
      apb(1, IRQ_OFFSET, 2);
      apb(1, CONTROL_OFFSET, 4 | outps[i] << 3);
      n = 0;
      while (tmr_out.irq !== 1'b1) begin
        @(posedge pclk);
        n += tmr_out.match_pulse;
      end
      chk(n, outps[i] + 1);
    end
    apb(1, IRQ_OFFSET, 1);
    rchk(IRQ_OFFSET, 1);
    chk(tmr_out.irq, 0);
    apb(1, SYS_OFFSET, 2);
    repeat (40) begin
      @(posedge pclk);
      chk(tmr_out.spi_shift_clock, tmr_out.match_pulse);
    end
    apb(1, SYS_OFFSET, 1);
    frozen();
    apb(1, SYS_OFFSET, 0);
    apb(1, CONTROL_OFFSET, 0);
    frozen();
    $display("interrupt and hold tests done");
    test_done();
  end
endmodule
